// File: bench/dhp_host_model.sv
// Purpose: Host processor on the asynchronous parallel bus
// Assumes: Pins change at the falling clock edge
// Notes:   Strobes are held long enough for the device synchroniser
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model
  import dhp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_bus,
  output var dhp_pins_t o_pins,
  output var logic o_drv
);
  initial begin
    o_pins = PINS_IDLE;
    o_drv = 1'b0;
  end
  // One bus cycle; the select pattern is free so refusals can be tried
  task automatic xfer(input logic wr, input logic [1:0] sel_n, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(negedge i_core_clk);
    o_pins.sel_n = sel_n;
    o_pins.addr = a;
    o_pins.data = d;
    o_drv = wr;
    repeat (2) @(negedge i_core_clk);
    if (wr) o_pins.wr_n = 1'b0;
    else o_pins.rd_n = 1'b0;
    repeat (10) @(negedge i_core_clk);
    q = i_bus;
    o_pins.rd_n = 1'b1;
    o_pins.wr_n = 1'b1;
    repeat (8) @(negedge i_core_clk);
    o_pins.sel_n = 2'h3;
    o_drv = 1'b0;
    repeat (8) @(negedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// File: bench/dhp_props.sv
// Purpose: Port-level checks of the dual-channel UART host port
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Strobe pins pass a synchroniser, so answers land a few clocks late
`timescale 1ns/1ps
`default_nettype none
module dhp_props (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_read_strobe_n,
  input wire logic i_chan0_select_n,
  input wire logic i_chan1_select_n,
  input wire logic [7:0] o_data_out,
  input wire logic o_data_oe,
  input wire logic o_chan0_irq_oe,
  input wire logic o_chan1_irq_oe,
  input wire logic o_chan0_aux_out_n,
  input wire logic o_chan1_aux_out_n,
  input wire logic o_chan0_serial_out,
  input wire logic o_chan1_serial_out
);
  // ----------------------------------------------------------------
  // Idle counters: cycles since read strobe was last low and since exactly one select was last active
  // ----------------------------------------------------------------
  logic [3:0] rd_hi_ff;
  logic [3:0] nosel_ff;
  logic [3:0] nxt_rd_hi;
  logic [3:0] nxt_nosel;
  always_comb begin
    nxt_rd_hi = !i_read_strobe_n ? 4'h0 : (rd_hi_ff == 4'hF) ? rd_hi_ff : rd_hi_ff + 4'h1;
    nxt_nosel = (i_chan0_select_n == i_chan1_select_n) ? ((nosel_ff == 4'hF) ? nosel_ff : nosel_ff + 4'h1) : 4'h0;
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_hi_ff <= 4'hF;
      nosel_ff <= 4'hF;
    end else begin
      rd_hi_ff <= nxt_rd_hi;
      nosel_ff <= nxt_nosel;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_rd_answer: assert property ($fell(i_read_strobe_n) && (i_chan0_select_n ^ i_chan1_select_n)
    |-> ##[3:7] o_data_oe) else $error("read strobe not answered");
  chk_rd_release: assert property ($rose(i_read_strobe_n) |-> ##[3:7] !o_data_oe)
    else $error("bus held after read");
  chk_oe_cause: assert property (o_data_oe |-> rd_hi_ff < 4'h8)
    else $error("bus driven without read");
  chk_sel_gate: assert property (o_data_oe |-> nosel_ff < 4'h8)
    else $error("bus driven without one select");
  chk_data_hold: assert property (o_data_oe && $past(o_data_oe) |-> $stable(o_data_out))
    else $error("read byte moved during strobe");
  chk_aux_irq0: assert property (o_chan0_irq_oe != o_chan0_aux_out_n)
    else $error("channel 0 aux and irq enable disagree");
  chk_aux_irq1: assert property (o_chan1_irq_oe != o_chan1_aux_out_n)
    else $error("channel 1 aux and irq enable disagree");
  chk_rst_idle: assert property ($fell(i_rst) |-> !o_data_oe && !o_chan0_irq_oe && !o_chan1_irq_oe
    && o_chan0_serial_out && o_chan1_serial_out) else $error("outputs not idle after reset");
  cover property (o_data_oe);
  cover property ($rose(o_chan0_irq_oe));
  cover property ($fell(o_chan1_serial_out));
endmodule
bind dhp_dual_uart_host_port dhp_props dhp_props_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_read_strobe_n(i_read_strobe_n), .i_chan0_select_n(i_chan0_select_n), .i_chan1_select_n(i_chan1_select_n),
  .o_data_out(o_data_out), .o_data_oe(o_data_oe), .o_chan0_irq_oe(o_chan0_irq_oe), .o_chan1_irq_oe(o_chan1_irq_oe),
  .o_chan0_aux_out_n(o_chan0_aux_out_n), .o_chan1_aux_out_n(o_chan1_aux_out_n),
  .o_chan0_serial_out(o_chan0_serial_out), .o_chan1_serial_out(o_chan1_serial_out));
`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench of the dual-channel UART host port
// Assumes: Channel serial lines are looped to each other
// Notes:   Fast baud rate makes one bit sixteen clocks
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dhp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] cts = 2'h3;
  logic [7:0] dout;
  logic [7:0] bus;
  logic [7:0] q;
  logic oe, drv, ioe0, ioe1, aux0, aux1, tx0, tx1, rts0, rts1, irq0, irq1;
  dhp_pins_t pins;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  // Released bus shows the inverse of the last host byte
  assign bus = oe ? dout : drv ? pins.data : ~pins.data;
  dhp_host_model dhp_host_model_inst (.i_core_clk(clk), .i_bus(bus), .o_pins(pins), .o_drv(drv));
  dhp_dual_uart_host_port #(.BAUD_RATE(625000)) dhp_dual_uart_host_port_inst (.i_core_clk(clk), .i_rst(rst),
    .i_reg_sel_bit2(pins.addr[2]), .i_reg_sel_bit1(pins.addr[1]), .i_reg_sel_bit0(pins.addr[0]),
    .i_data_in(bus), .o_data_out(dout), .o_data_oe(oe), .i_read_strobe_n(pins.rd_n),
    .i_write_strobe_n(pins.wr_n), .i_chan0_select_n(pins.sel_n[0]), .i_chan1_select_n(pins.sel_n[1]),
    .o_chan0_irq(irq0), .o_chan0_irq_oe(ioe0), .o_chan1_irq(irq1), .o_chan1_irq_oe(ioe1),
    .o_chan0_aux_out_n(aux0), .o_chan1_aux_out_n(aux1), .o_chan0_serial_out(tx0), .o_chan1_serial_out(tx1),
    .i_chan0_serial_in(tx1), .i_chan1_serial_in(tx0),
    .o_chan0_request_to_send_n(rts0), .o_chan1_request_to_send_n(rts1),
    .i_chan0_clear_to_send_n(cts[0]), .i_chan1_clear_to_send_n(cts[1]));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] x;
    dhp_host_model_inst.xfer(1'b1, s, a, d, x);
  endtask
  task automatic rd(input logic [1:0] s, input logic [2:0] a, output logic [7:0] r);
    dhp_host_model_inst.xfer(1'b0, s, a, 8'h00, r);
  endtask
  task automatic t_regs();
    rd(2'h2, REG_LINE, q);
    chk(q, LINE_RESET);
    wr(2'h2, REG_SCRATCH, 8'hA5);
    wr(2'h1, REG_SCRATCH, 8'h5A);
    rd(2'h2, REG_SCRATCH, q);
    chk(q, 8'hA5);
    rd(2'h1, REG_SCRATCH, q);
    chk(q, 8'h5A);
    $display("t_regs done");
  endtask
  task automatic t_modem();
    wr(2'h2, REG_MODEM, 8'h09);
    chk({ioe0, aux0, rts0, ioe1, aux1, rts1, 2'h0}, 8'h8C);
    wr(2'h1, REG_MODEM, 8'h08);
    chk({ioe1, aux1, rts1, 5'h00}, 8'hA0);
    wr(2'h2, REG_MODEM, 8'h00);
    wr(2'h1, REG_MODEM, 8'h00);
    chk({ioe0, aux0, rts0, ioe1, aux1, rts1, 2'h0}, 8'h6C);
    $display("t_modem done");
  endtask
  task automatic t_refuse();
    wr(2'h3, REG_SCRATCH, 8'hFF);
    wr(2'h0, REG_SCRATCH, 8'hEE);
    // Undriven bus shows the inverse of the host byte
    rd(2'h3, REG_SCRATCH, q);
    chk(q, ~8'h00);
    rd(2'h2, REG_SCRATCH, q);
    chk(q, 8'hA5);
    $display("t_refuse done");
  endtask
  task automatic t_cts();
    cts = 2'h2;
    rd(2'h2, REG_MSTAT, q);
    chk(q & 8'h10, 8'h10);
    rd(2'h1, REG_MSTAT, q);
    chk(q & 8'h10, 8'h00);
    chk({tx0, tx1, 6'h00}, 8'hC0);
    cts = 2'h3;
    $display("t_cts done");
  endtask
  task automatic t_serial();
    logic [7:0] ln;
    logic [7:0] m;
    for (int n = 5; n <= 8; n++) begin
      // Even, odd, even, then no parity
      ln = 8'(n - 5) | ((n < 8) ? 8'h08 : 8'h00) | ((n % 2) ? 8'h10 : 8'h00);
      m = 8'hFF >> (8 - n);
      wr(2'h2, REG_LINE, ln);
      wr(2'h1, REG_LINE, ln);
      wr(2'h2, REG_DATA, 8'hA7);
      wr(2'h1, REG_DATA, 8'h3C);
      repeat (400) @(negedge clk);
      chk({irq0, irq1, 6'h00}, 8'hC0);
      rd(2'h1, REG_STATUS, q);
      chk(q & 8'h0F, 8'h01);
      rd(2'h1, REG_DATA, q);
      chk(q & m, 8'hA7 & m);
      rd(2'h2, REG_STATUS, q);
      chk(q & 8'h0F, 8'h01);
      rd(2'h2, REG_DATA, q);
      chk(q & m, 8'h3C & m);
      chk({irq0, irq1, 6'h00}, 8'h00);
    end
    $display("t_serial done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk({tx0, tx1, aux0, aux1, ioe0, ioe1, oe, 1'b0}, 8'hF0);
    t_regs();
    t_modem();
    t_refuse();
    t_cts();
    t_serial();
    wrap_up();
  end
endmodule
`default_nettype wire

// File: rtl/dhp_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock
// Notes:   Entry zero is always the head
`timescale 1ns/1ps
`default_nettype none
module dhp_buf2 #(
  parameter int W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);

  logic [W-1:0] ent0_ff, ent1_ff, nxt_ent0, nxt_ent1;
  logic [1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  always_comb begin
    push = i_in_valid && (cnt_ff != 2'h2);
    pop = i_out_ready && (cnt_ff != 2'h0);
    nxt_ent0 = ent0_ff;
    nxt_ent1 = ent1_ff;
    nxt_cnt = cnt_ff;
    if (pop) begin
      nxt_ent0 = ent1_ff;
    end
    if (push) begin
      if ((cnt_ff == 2'h0) || (cnt_ff == 2'h1 && pop)) begin
        nxt_ent0 = i_in_data;
      end else begin
        nxt_ent1 = i_in_data;
      end
    end
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ent0_ff <= '0;
      ent1_ff <= '0;
      cnt_ff <= 2'h0;
    end else begin
      ent0_ff <= nxt_ent0;
      ent1_ff <= nxt_ent1;
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_in_ready = (cnt_ff != 2'h2);
  assign o_out_valid = (cnt_ff != 2'h0);
  assign o_out_data = ent0_ff;

endmodule
`default_nettype wire

// File: rtl/dhp_dual_uart_host_port.sv
// Purpose: Host bus port and two serial channels of a dual UART
// Assumes: Host strobes and serial pins are asynchronous to i_core_clk
// Notes:   Bus strobes are sampled; bus cycles must span several clocks
//
// Functional notes
// - Three address lines pick channel register
// - Eight-bit data bus, driven on reads
// - Read strobe fall fetches addressed register
// - Byte driven during strobe; host samples rise
// - Write stored on write strobe rising edge
// - One active-low select per channel
// - Modem bit3 set: irq driven, aux low
// - Modem bit3 clear: irq floats, aux high
// - Second channel applies same bit3 behaviour
// - Request-to-send is a handshake or general output
// - Five to eight bits, even/odd/no parity
// - One transmit byte, one tagged receive byte plus two buffered tagged words
// - Two independent channels with own registers
`timescale 1ns/1ps
`default_nettype none
module dhp_dual_uart_host_port
  import dhp_pkg::*;
#(
  parameter int BAUD_RATE = BAUD_DEFAULT
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_reg_sel_bit2,
  input wire logic i_reg_sel_bit1,
  input wire logic i_reg_sel_bit0,
  input wire logic [7:0] i_data_in,
  output logic [7:0] o_data_out,
  output logic o_data_oe,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic i_chan0_select_n,
  input wire logic i_chan1_select_n,
  output logic o_chan0_irq,
  output logic o_chan0_irq_oe,
  output logic o_chan1_irq,
  output logic o_chan1_irq_oe,
  output logic o_chan0_aux_out_n,
  output logic o_chan1_aux_out_n,
  output logic o_chan0_serial_out,
  output logic o_chan1_serial_out,
  input wire logic i_chan0_serial_in,
  input wire logic i_chan1_serial_in,
  output logic o_chan0_request_to_send_n,
  output logic o_chan1_request_to_send_n,
  input wire logic i_chan0_clear_to_send_n,
  input wire logic i_chan1_clear_to_send_n
);

  // ----------------------------------------------------------------
  // Pin synchronisation and strobe edges
  // ----------------------------------------------------------------
  localparam int OVS_CYCLES_RAW = CLK_HZ / (BAUD_RATE * OVS_RATE);
  localparam int OVS_CYCLES = (OVS_CYCLES_RAW < 1) ? 1 : OVS_CYCLES_RAW;
  localparam logic [15:0] OVS_TOP = 16'(OVS_CYCLES - 1);

  dhp_pins_t pins_raw, pins;
  logic rd_prev_ff, wr_prev_ff, nxt_rd_prev, nxt_wr_prev;
  logic rd_fall, rd_rise, wr_rise;
  logic [NUM_CHAN-1:0] sel;
  logic any_sel;

  always_comb begin
    pins_raw.rd_n = i_read_strobe_n;
    pins_raw.wr_n = i_write_strobe_n;
    pins_raw.sel_n = {i_chan1_select_n, i_chan0_select_n};
    pins_raw.addr = {i_reg_sel_bit2, i_reg_sel_bit1, i_reg_sel_bit0};
    pins_raw.data = i_data_in;
    pins_raw.rxd = {i_chan1_serial_in, i_chan0_serial_in};
    pins_raw.cts_n = {i_chan1_clear_to_send_n, i_chan0_clear_to_send_n};
  end

  dhp_sync #(.W(PINS_W), .RST_VAL(PINS_IDLE)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(pins_raw),
    .o_level(pins)
  );

  always_comb begin
    nxt_rd_prev = pins.rd_n;
    nxt_wr_prev = pins.wr_n;
    // Exactly one select may steer a bus cycle
    sel = ~pins.sel_n;
    any_sel = (sel == 2'h1) || (sel == 2'h2);
    rd_fall = rd_prev_ff && !pins.rd_n && any_sel;
    rd_rise = !rd_prev_ff && pins.rd_n && any_sel;
    wr_rise = !wr_prev_ff && pins.wr_n && any_sel;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_prev_ff <= 1'b1;
      wr_prev_ff <= 1'b1;
    end else begin
      rd_prev_ff <= nxt_rd_prev;
      wr_prev_ff <= nxt_wr_prev;
    end
  end

  // ----------------------------------------------------------------
  // Oversampling tick
  // ----------------------------------------------------------------
  logic [15:0] ovs_cnt_ff, nxt_ovs_cnt;
  logic ovs_tick_ff, nxt_ovs_tick;

  always_comb begin
    nxt_ovs_tick = (ovs_cnt_ff == OVS_TOP);
    nxt_ovs_cnt = nxt_ovs_tick ? 16'h0000 : ovs_cnt_ff + 16'h0001;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ovs_cnt_ff <= 16'h0000;
      ovs_tick_ff <= 1'b0;
    end else begin
      ovs_cnt_ff <= nxt_ovs_cnt;
      ovs_tick_ff <= nxt_ovs_tick;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic [7:0] rd_val [NUM_CHAN];
  logic [NUM_CHAN-1:0] irq_q, irq_oe_q, aux_n_q, txd_q, rts_n_q;

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    logic [7:0] line_ff, modem_ff, scratch_ff, thr_ff;
    logic [7:0] nxt_line, nxt_modem, nxt_scratch, nxt_thr;
    logic thr_full_ff, rx_ready_ff, overrun_ff, nxt_thr_full, nxt_rx_ready, nxt_overrun;
    dhp_rx_word_t rxh_ff, nxt_rxh;
    dhp_ser_state_t tx_st_ff, rx_st_ff, nxt_tx_st, nxt_rx_st;
    logic [7:0] tx_sh_ff, rx_sh_ff, nxt_tx_sh, nxt_rx_sh;
    logic [2:0] tx_bit_ff, rx_bit_ff, nxt_tx_bit, nxt_rx_bit;
    logic [3:0] tx_ovs_ff, rx_ovs_ff, nxt_tx_ovs, nxt_rx_ovs;
    logic tx_par_ff, rx_par_ff, nxt_tx_par, nxt_rx_par;
    logic txd_ff, irq_ff, irq_oe_ff, aux_n_ff, rts_n_ff;
    logic nxt_txd, nxt_irq, nxt_irq_oe, nxt_aux_n, nxt_rts_n;
    logic rx_pe_ff, nxt_rx_pe;
    logic [2:0] last_bit;
    logic par_en, par_even, acc_cs;
    logic rxw_valid, rxw_ready, buf_valid, buf_take;
    dhp_rx_word_t rxw, buf_word;

    assign acc_cs = sel[c] && any_sel;
    assign buf_take = buf_valid && !rx_ready_ff;

    // Tagged receive words wait here while the holding byte is unread
    dhp_buf2 #(.W(RXW_W)) u_rxbuf (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_in_valid(rxw_valid),
      .i_in_data(rxw),
      .o_in_ready(rxw_ready),
      .o_out_valid(buf_valid),
      .o_out_data(buf_word),
      .i_out_ready(!rx_ready_ff)
    );

    always_comb begin
      rd_val[c] = ZERO_BYTE;
      if (pins.addr == REG_DATA) begin
        rd_val[c] = rxh_ff.data;
      end else if (pins.addr == REG_LINE) begin
        rd_val[c] = line_ff;
      end else if (pins.addr == REG_MODEM) begin
        rd_val[c] = modem_ff;
      end else if (pins.addr == REG_STATUS) begin
        rd_val[c][STAT_RX_READY] = rx_ready_ff;
        rd_val[c][STAT_OVERRUN] = overrun_ff;
        rd_val[c][STAT_PAR_ERR] = rxh_ff.par_err;
        rd_val[c][STAT_FRAME_ERR] = rxh_ff.frame_err;
        rd_val[c][STAT_THR_EMPTY] = !thr_full_ff;
        rd_val[c][STAT_TX_IDLE] = !thr_full_ff && (tx_st_ff == SER_IDLE);
      end else if (pins.addr == REG_MSTAT) begin
        rd_val[c][MSTAT_CTS] = !pins.cts_n[c];
      end else if (pins.addr == REG_SCRATCH) begin
        rd_val[c] = scratch_ff;
      end
    end

    always_comb begin
      nxt_line = line_ff;
      nxt_modem = modem_ff;
      nxt_scratch = scratch_ff;
      nxt_thr = thr_ff;
      nxt_thr_full = thr_full_ff;
      nxt_rx_ready = rx_ready_ff;
      nxt_overrun = overrun_ff;
      nxt_rxh = rxh_ff;
      nxt_tx_st = tx_st_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_tx_bit = tx_bit_ff;
      nxt_tx_ovs = tx_ovs_ff;
      nxt_tx_par = tx_par_ff;
      nxt_txd = txd_ff;
      nxt_rx_st = rx_st_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_bit = rx_bit_ff;
      nxt_rx_ovs = rx_ovs_ff;
      nxt_rx_par = rx_par_ff;
      nxt_rx_pe = rx_pe_ff;
      rxw_valid = 1'b0;
      rxw = '{data: rx_sh_ff, par_err: rx_pe_ff, frame_err: 1'b0};
      last_bit = line_ff[LINE_LEN_LSB +: 2] + 3'(MIN_CHAR_LEN - 1);
      par_en = line_ff[LINE_PAR_EN];
      par_even = line_ff[LINE_PAR_EVEN];

      // Transmitter
      if (tx_st_ff == SER_IDLE) begin
        nxt_txd = 1'b1;
        if (thr_full_ff) begin
          nxt_tx_sh = thr_ff;
          nxt_thr_full = 1'b0;
          nxt_tx_st = SER_START;
          nxt_tx_ovs = 4'h0;
          nxt_tx_bit = 3'h0;
          nxt_tx_par = !par_even;
          nxt_txd = 1'b0;
        end
      end else if (ovs_tick_ff) begin
        nxt_tx_ovs = tx_ovs_ff + 4'h1;
        if (tx_ovs_ff == OVS_LAST) begin
          case (tx_st_ff)
            SER_START, SER_DATA: begin
              if (tx_st_ff == SER_DATA && tx_bit_ff == last_bit) begin
                nxt_tx_st = par_en ? SER_PARITY : SER_STOP;
                nxt_txd = par_en ? tx_par_ff : 1'b1;
              end else begin
                nxt_tx_st = SER_DATA;
                nxt_txd = tx_sh_ff[0];
                nxt_tx_par = tx_par_ff ^ tx_sh_ff[0];
                nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
                nxt_tx_bit = (tx_st_ff == SER_START) ? 3'h0 : tx_bit_ff + 3'h1;
              end
            end
            SER_PARITY: begin
              nxt_tx_st = SER_STOP;
              nxt_txd = 1'b1;
            end
            default: begin
              nxt_tx_st = SER_IDLE;
              nxt_txd = 1'b1;
            end
          endcase
        end
      end

      // Receiver; the line idles high
      if (ovs_tick_ff) begin
        nxt_rx_ovs = rx_ovs_ff + 4'h1;
        case (rx_st_ff)
          SER_IDLE: begin
            nxt_rx_ovs = 4'h0;
            if (!pins.rxd[c]) begin
              nxt_rx_st = SER_START;
            end
          end
          SER_START: begin
            if (rx_ovs_ff == OVS_HALF) begin
              nxt_rx_ovs = 4'h0;
              nxt_rx_bit = 3'h0;
              nxt_rx_par = !par_even;
              nxt_rx_sh = ZERO_BYTE;
              nxt_rx_pe = 1'b0;
              nxt_rx_st = pins.rxd[c] ? SER_IDLE : SER_DATA;
            end
          end
          SER_DATA: begin
            if (rx_ovs_ff == OVS_LAST) begin
              nxt_rx_sh[rx_bit_ff] = pins.rxd[c];
              nxt_rx_par = rx_par_ff ^ pins.rxd[c];
              nxt_rx_bit = rx_bit_ff + 3'h1;
              if (rx_bit_ff == last_bit) begin
                nxt_rx_st = par_en ? SER_PARITY : SER_STOP;
              end
            end
          end
          SER_PARITY: begin
            if (rx_ovs_ff == OVS_LAST) begin
              nxt_rx_pe = (rx_par_ff != pins.rxd[c]);
              nxt_rx_st = SER_STOP;
            end
          end
          default: begin
            if (rx_ovs_ff == OVS_LAST) begin
              rxw_valid = 1'b1;
              rxw.frame_err = !pins.rxd[c];
              nxt_rx_st = SER_IDLE;
            end
          end
        endcase
      end

      // Host reads: clears before sets so a new event wins
      if (rd_rise && acc_cs && pins.addr == REG_DATA) begin
        nxt_rx_ready = 1'b0;
      end
      if (rd_rise && acc_cs && pins.addr == REG_STATUS) begin
        nxt_overrun = 1'b0;
      end
      if (buf_take) begin
        nxt_rxh = buf_word;
        nxt_rx_ready = 1'b1;
      end
      if (rxw_valid && !rxw_ready) begin
        nxt_overrun = 1'b1;
      end

      // Host writes, stored at the strobe's rising edge
      if (wr_rise && acc_cs) begin
        if (pins.addr == REG_DATA) begin
          nxt_thr = pins.data;
          nxt_thr_full = 1'b1;
        end else if (pins.addr == REG_LINE) begin
          nxt_line = pins.data;
        end else if (pins.addr == REG_MODEM) begin
          nxt_modem = pins.data;
        end else if (pins.addr == REG_SCRATCH) begin
          nxt_scratch = pins.data;
        end
      end

      // Interrupt pin mode follows modem bit 3
      nxt_irq = rx_ready_ff || overrun_ff;
      nxt_irq_oe = modem_ff[MODEM_IRQ_EN];
      nxt_aux_n = !modem_ff[MODEM_IRQ_EN];
      nxt_rts_n = !modem_ff[MODEM_RTS];
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        line_ff <= LINE_RESET;
        modem_ff <= ZERO_BYTE;
        scratch_ff <= ZERO_BYTE;
        thr_ff <= ZERO_BYTE;
        thr_full_ff <= 1'b0;
        rx_ready_ff <= 1'b0;
        overrun_ff <= 1'b0;
        rxh_ff <= '0;
        tx_st_ff <= SER_IDLE;
        tx_sh_ff <= ZERO_BYTE;
        tx_bit_ff <= 3'h0;
        tx_ovs_ff <= 4'h0;
        tx_par_ff <= 1'b0;
        txd_ff <= 1'b1;
        rx_st_ff <= SER_IDLE;
        rx_sh_ff <= ZERO_BYTE;
        rx_bit_ff <= 3'h0;
        rx_ovs_ff <= 4'h0;
        rx_par_ff <= 1'b0;
        rx_pe_ff <= 1'b0;
        irq_ff <= 1'b0;
        irq_oe_ff <= 1'b0;
        aux_n_ff <= 1'b1;
        rts_n_ff <= 1'b1;
      end else begin
        line_ff <= nxt_line;
        modem_ff <= nxt_modem;
        scratch_ff <= nxt_scratch;
        thr_ff <= nxt_thr;
        thr_full_ff <= nxt_thr_full;
        rx_ready_ff <= nxt_rx_ready;
        overrun_ff <= nxt_overrun;
        rxh_ff <= nxt_rxh;
        tx_st_ff <= nxt_tx_st;
        tx_sh_ff <= nxt_tx_sh;
        tx_bit_ff <= nxt_tx_bit;
        tx_ovs_ff <= nxt_tx_ovs;
        tx_par_ff <= nxt_tx_par;
        txd_ff <= nxt_txd;
        rx_st_ff <= nxt_rx_st;
        rx_sh_ff <= nxt_rx_sh;
        rx_bit_ff <= nxt_rx_bit;
        rx_ovs_ff <= nxt_rx_ovs;
        rx_par_ff <= nxt_rx_par;
        rx_pe_ff <= nxt_rx_pe;
        irq_ff <= nxt_irq;
        irq_oe_ff <= nxt_irq_oe;
        aux_n_ff <= nxt_aux_n;
        rts_n_ff <= nxt_rts_n;
      end
    end

    assign irq_q[c] = irq_ff;
    assign irq_oe_q[c] = irq_oe_ff;
    assign aux_n_q[c] = aux_n_ff;
    assign txd_q[c] = txd_ff;
    assign rts_n_q[c] = rts_n_ff;
  end

  // ----------------------------------------------------------------
  // Data bus drive
  // ----------------------------------------------------------------
  logic [7:0] dout_ff, nxt_dout;
  logic doe_ff, nxt_doe;

  always_comb begin
    nxt_dout = dout_ff;
    if (rd_fall) begin
      nxt_dout = sel[1] ? rd_val[1] : rd_val[0];
    end
    // Drive only while a selected read strobe is low
    nxt_doe = !pins.rd_n && any_sel && (doe_ff || rd_fall);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      dout_ff <= ZERO_BYTE;
      doe_ff <= 1'b0;
    end else begin
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
    end
  end

  assign o_data_out = dout_ff;
  assign o_data_oe = doe_ff;
  assign o_chan0_irq = irq_q[0];
  assign o_chan1_irq = irq_q[1];
  assign o_chan0_irq_oe = irq_oe_q[0];
  assign o_chan1_irq_oe = irq_oe_q[1];
  assign o_chan0_aux_out_n = aux_n_q[0];
  assign o_chan1_aux_out_n = aux_n_q[1];
  assign o_chan0_serial_out = txd_q[0];
  assign o_chan1_serial_out = txd_q[1];
  assign o_chan0_request_to_send_n = rts_n_q[0];
  assign o_chan1_request_to_send_n = rts_n_q[1];

endmodule
`default_nettype wire

// File: rtl/dhp_sync.sv
// Purpose: Three-stage synchroniser for a bundle of pin inputs
// Assumes: Inputs are asynchronous to i_core_clk
// Notes:   A bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dhp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);

  logic [W-1:0] s1_ff, s2_ff, s3_ff, level_ff;
  logic [W-1:0] nxt_level;

  always_comb begin
    nxt_level = ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & level_ff);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      level_ff <= RST_VAL;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign o_level = level_ff;

endmodule
`default_nettype wire

// File: shared/dhp_pkg.sv
// Purpose: Shared constants and types of the dual-channel UART host port
// Assumes: 10 MHz core clock, register select on three address lines
// Notes:   Offsets are register selects inside one channel
package dhp_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 2;
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_DEFAULT = 9600;
  localparam int OVS_RATE = 16;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_HALF = 4'h7;
  localparam int MIN_CHAR_LEN = 5;

  // ----------------------------------------------------------------
  // Register selects
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_LINE = 3'h3;
  localparam logic [2:0] REG_MODEM = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [2:0] REG_MSTAT = 3'h6;
  localparam logic [2:0] REG_SCRATCH = 3'h7;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LINE_LEN_LSB = 0;
  localparam int LINE_PAR_EN = 3;
  localparam int LINE_PAR_EVEN = 4;
  localparam int MODEM_RTS = 0;
  localparam int MODEM_IRQ_EN = 3;
  localparam int MSTAT_CTS = 4;
  localparam int STAT_RX_READY = 0;
  localparam int STAT_OVERRUN = 1;
  localparam int STAT_PAR_ERR = 2;
  localparam int STAT_FRAME_ERR = 3;
  localparam int STAT_THR_EMPTY = 5;
  localparam int STAT_TX_IDLE = 6;
  localparam logic [7:0] LINE_RESET = 8'h03;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic [1:0] sel_n;
    logic [2:0] addr;
    logic [7:0] data;
    logic [1:0] rxd;
    logic [1:0] cts_n;
  } dhp_pins_t;

  localparam int PINS_W = $bits(dhp_pins_t);
  localparam dhp_pins_t PINS_IDLE = '{rd_n: 1'b1, wr_n: 1'b1, sel_n: 2'h3, addr: 3'h0,
                                      data: 8'h00, rxd: 2'h3, cts_n: 2'h3};

  typedef struct packed {
    logic [7:0] data;
    logic par_err;
    logic frame_err;
  } dhp_rx_word_t;

  localparam int RXW_W = $bits(dhp_rx_word_t);

  typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PARITY, SER_STOP} dhp_ser_state_t;

endpackage
